/* File: verilog/passive_panel_sync_timing.sv */
// Purpose: Line sync, frame sync and shift clock generator for a passive panel
// Assumes: Registers on mclk, panel logic on display_source_clock
// Notes: Config is sampled into the panel domain by a toggle handshake
// Notes: Enable starts the sequencer at once but stops it only at the end of a line's last wait, other settings only while idle
// Notes: Bus width zero gives sixteen pixel ticks per shift period
// Notes: Bus answers one cycle after a request, for one cycle
//
// Our own choices: the Avalon-MM register port and the register offsets.
`include "panel_sync_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module passive_panel_sync_timing (
  // System
  input wire logic mclk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Panel
  input wire logic display_source_clock,
  input wire logic [7:0] pixel_in,
  output logic frame_sync,
  output logic line_sync,
  output logic shift_clk,
  output logic [7:0] panel_data_lines
);
  // Reset release for the register side
  logic rs1_r;
  logic rst_n_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n_r <= rs1_r;
    end
  end

  // Reset release for the panel side
  logic prs1_r;
  logic prst_n_r;
  always_ff @(posedge display_source_clock or negedge arst_n) begin
    if (!arst_n) begin
      prs1_r <= 1'b0;
      prst_n_r <= 1'b0;
    end else begin
      prs1_r <= 1'b1;
      prst_n_r <= prs1_r;
    end
  end

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Interval length in pixel ticks: field plus fixed extra
  function automatic logic [15:0] ticks(input logic [7:0] field, input logic [7:0] extra);
    ticks = {8'h00, field} + {8'h00, extra};
  endfunction

  // Control fields packed to the register layout
  function automatic logic [31:0] ctrl_pack(input panel_sync_pkg::ctrl_s c);
    ctrl_pack = {16'h0000, c.pixel_clock_divisor, c.bus_width, c.shift_pol, c.line_pol, c.frame_pol,
                 c.enable};
  endfunction

  // Register word unpacked to the control fields
  function automatic panel_sync_pkg::ctrl_s ctrl_unpack(input logic [31:0] w);
    ctrl_unpack.enable = w[`CTRL_EN_BIT];
    ctrl_unpack.frame_pol = w[`CTRL_FPOL_BIT];
    ctrl_unpack.line_pol = w[`CTRL_LPOL_BIT];
    ctrl_unpack.shift_pol = w[`CTRL_SPOL_BIT];
    ctrl_unpack.bus_width = w[`CTRL_BUS_LSB +: 4];
    ctrl_unpack.pixel_clock_divisor = w[`CTRL_PCD_LSB +: 8];
  endfunction

  // Register side state
  panel_sync_pkg::ctrl_s ctrl_r;
  panel_sync_pkg::timing_s timing_r;
  panel_sync_pkg::geom_s geom_r;
  logic ack_r;
  logic cfg_tgl_r;
  logic [2:0] fs_s;
  logic [2:0] ls_s;
  logic [2:0] act_s;

  // Panel side state, declared here as the status path samples it
  panel_sync_pkg::ctrl_s pc_r;
  panel_sync_pkg::timing_s pt_r;
  panel_sync_pkg::geom_s pg_r;
  panel_sync_pkg::seq_e st_r;
  panel_sync_pkg::seq_e st_nxt;
  logic [2:0] tg_s;
  logic [7:0] div_r;
  logic [3:0] bit_r;
  logic [15:0] cnt_r;
  logic [15:0] pix_r;
  logic [15:0] row_r;
  logic frame_r;
  logic line_r;
  logic sclk_r;
  logic run_r;
  logic first_r;

  // Address decode and read selection
  wire sel_ctrl = avs_address == `CTRL_OFS;
  wire sel_timing = avs_address == `TIMING_OFS;
  wire sel_geom = avs_address == `GEOM_OFS;
  wire sel_status = avs_address == `STATUS_OFS;
  wire req = (avs_read | avs_write) & ~ack_r;
  wire do_wr = avs_write & ~ack_r;
  wire wr_cfg = do_wr & (sel_ctrl | sel_timing | sel_geom);
  wire [31:0] ctrl_word = ctrl_pack(ctrl_r);
  wire [31:0] timing_word = {8'h00, timing_r};
  wire [31:0] geom_word = geom_r;
  wire [31:0] status_word = {29'h0, act_s[2], fs_s[2], ls_s[2]};
  wire [31:0] wr_ctrl = merge(ctrl_word, avs_writedata, avs_byteenable);
  wire [31:0] wr_timing = merge(timing_word, avs_writedata, avs_byteenable);
  wire [31:0] wr_geom = merge(geom_word, avs_writedata, avs_byteenable);
  // Unmapped offsets read as zero
  logic [31:0] rd_mux;
  always_comb begin
    if (sel_ctrl) begin
      rd_mux = ctrl_word;
    end else if (sel_timing) begin
      rd_mux = timing_word;
    end else if (sel_geom) begin
      rd_mux = geom_word;
    end else if (sel_status) begin
      rd_mux = status_word;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Bus handshake: one wait cycle, answer held for one cycle
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      avs_waitrequest <= ~req;
      if (avs_read) begin
        avs_readdata <= rd_mux;
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration registers and change toggle
  // Write lands at the edge that takes the request
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= ctrl_unpack(`CTRL_RESET);
      timing_r <= 24'(`TIMING_RESET);
      geom_r <= `GEOM_RESET;
      cfg_tgl_r <= 1'b0;
    end else begin
      if (do_wr && sel_ctrl) begin
        ctrl_r <= ctrl_unpack(wr_ctrl);
      end
      if (do_wr && sel_timing) begin
        timing_r <= wr_timing[23:0];
      end
      if (do_wr && sel_geom) begin
        geom_r <= wr_geom;
      end
      if (wr_cfg) begin
        cfg_tgl_r <= ~cfg_tgl_r;
      end
    end
  end

  // Status flags from the panel side, three-stage sampled
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fs_s <= 3'h0;
      ls_s <= 3'h0;
      act_s <= 3'h0;
    end else begin
      fs_s <= {fs_s[1:0], frame_r};
      ls_s <= {ls_s[1:0], line_r};
      act_s <= {act_s[1:0], run_r};
    end
  end

  // Panel side decode
  wire cfg_new = tg_s[2] ^ tg_s[1];
  wire pix_tick = div_r == pc_r.pixel_clock_divisor;
  wire sh_last = bit_r == pc_r.bus_width - 4'h1;
  wire row_end = pix_r == pg_r.pixels - 16'h0001;
  wire frame_end = row_r == pg_r.lines - 16'h0001;
  wire [15:0] s2l_n = ticks(pt_r.s2l_wait, `S2L_EXTRA);
  wire [15:0] wid_n = ticks(pt_r.line_width, `WIDTH_EXTRA);
  wire [15:0] l2f_n = ticks(pt_r.l2f_wait, `L2F_EXTRA);
  wire cnt_done = pix_tick && cnt_r == 16'h0001;
  wire in_shift = st_r == panel_sync_pkg::st_shift;
  wire shift_tick = in_shift && pix_tick;
  wire [3:0] half_bits = {1'b0, pc_r.bus_width[3:1]};

  // Sequencer: shift, wait, line pulse, wait, repeat
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      panel_sync_pkg::st_idle: begin
        if (run_r && pix_tick) begin
          st_nxt = panel_sync_pkg::st_shift;
        end
      end
      panel_sync_pkg::st_shift: begin
        if (pix_tick && sh_last && row_end) begin
          st_nxt = panel_sync_pkg::st_s2l;
        end
      end
      panel_sync_pkg::st_s2l: begin
        if (cnt_done) begin
          st_nxt = panel_sync_pkg::st_line;
        end
      end
      panel_sync_pkg::st_line: begin
        if (cnt_done) begin
          st_nxt = panel_sync_pkg::st_l2f;
        end
      end
      panel_sync_pkg::st_l2f: begin
        if (cnt_done && run_r) begin
          st_nxt = panel_sync_pkg::st_shift;
        end else if (cnt_done) begin
          st_nxt = panel_sync_pkg::st_idle;
        end
      end
      default: begin
        st_nxt = panel_sync_pkg::st_idle;
      end
    endcase
  end

  // Config capture: words are stable once the toggle has crossed
  // Only enable passes while a line is in progress
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      tg_s <= 3'h0;
      pc_r <= ctrl_unpack(`CTRL_RESET);
      pt_r <= 24'(`TIMING_RESET);
      pg_r <= `GEOM_RESET;
      run_r <= 1'b0;
    end else begin
      tg_s <= {tg_s[1:0], cfg_tgl_r};
      if (cfg_new && st_r == panel_sync_pkg::st_idle) begin
        pc_r <= ctrl_r;
        pt_r <= timing_r;
        pg_r <= geom_r;
      end
      if (cfg_new) begin
        run_r <= ctrl_r.enable;
      end
    end
  end

  // Sequencer state and pixel divider
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      st_r <= panel_sync_pkg::st_idle;
      div_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (pix_tick) begin
        div_r <= 8'h00;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // Shift clock and pixel counters
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      bit_r <= 4'h0;
      sclk_r <= 1'b0;
      pix_r <= 16'h0000;
    end else if (shift_tick) begin
      bit_r <= sh_last ? 4'h0 : bit_r + 4'h1;
      sclk_r <= bit_r < half_bits;
      if (sh_last && row_end) begin
        pix_r <= 16'h0000;
      end else if (sh_last) begin
        pix_r <= pix_r + 16'h0001;
      end
    end else if (!in_shift) begin
      bit_r <= 4'h0;
      sclk_r <= 1'b0;
    end
  end

  // Interval counter, reloaded on every state change
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      cnt_r <= 16'h0000;
    end else if (st_nxt == panel_sync_pkg::st_s2l && st_r != st_nxt) begin
      cnt_r <= s2l_n;
    end else if (st_nxt == panel_sync_pkg::st_line && st_r != st_nxt) begin
      cnt_r <= wid_n;
    end else if (st_r != st_nxt) begin
      cnt_r <= l2f_n;
    end else if (pix_tick && cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // Line pulse and row count
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      line_r <= 1'b0;
      row_r <= 16'h0000;
    end else begin
      line_r <= st_nxt == panel_sync_pkg::st_line;
      if (st_r == panel_sync_pkg::st_line && cnt_done && frame_end) begin
        row_r <= 16'h0000;
      end else if (st_r == panel_sync_pkg::st_line && cnt_done) begin
        row_r <= row_r + 16'h0001;
      end
    end
  end

  // Frame pulse: raised after the last line's wait, dropped at the first shift
  wire frame_start = st_r == panel_sync_pkg::st_l2f && cnt_done && row_r == 16'h0000;
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      frame_r <= 1'b0;
      first_r <= 1'b0;
    end else if (frame_start) begin
      frame_r <= 1'b1;
      first_r <= 1'b1;
    end else if (shift_tick) begin
      if (first_r) begin
        frame_r <= 1'b0;
      end
      first_r <= 1'b0;
    end
  end

  // Output flops with selectable polarity
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      frame_sync <= 1'b0;
      line_sync <= 1'b0;
      shift_clk <= 1'b0;
    end else begin
      frame_sync <= frame_r ^ pc_r.frame_pol;
      line_sync <= line_r ^ pc_r.line_pol;
      shift_clk <= sclk_r ^ pc_r.shift_pol;
    end
  end

  // Pixel data latched at the start of each shift period
  always_ff @(posedge display_source_clock or negedge prst_n_r) begin
    if (!prst_n_r) begin
      panel_data_lines <= 8'h00;
    end else if (shift_tick && bit_r == 4'h0) begin
      panel_data_lines <= pixel_in;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/panel_sync_regs.svh */
// Purpose: Offsets, fields, reset values and timing figures of the panel sync block
// Assumes: Avalon-MM word addressing by byte offset, 32-bit data
// Notes: Included by the package user and the design
`ifndef PANEL_SYNC_REGS_SVH
`define PANEL_SYNC_REGS_SVH
`define CTRL_OFS 4'h0
`define TIMING_OFS 4'h4
`define GEOM_OFS 4'h8
`define STATUS_OFS 4'hc
`define CTRL_EN_BIT 0
`define CTRL_FPOL_BIT 1
`define CTRL_LPOL_BIT 2
`define CTRL_SPOL_BIT 3
`define CTRL_BUS_LSB 4
`define CTRL_PCD_LSB 8
`define CTRL_RESET 32'h0000_0000
`define TIMING_RESET 32'h0000_0000
`define GEOM_RESET 32'h0004_0010
`define L2F_EXTRA 8'h02
`define WIDTH_EXTRA 8'h01
`define S2L_EXTRA 8'h01
`define MAX_SRC_MHZ 48
`define BUS_DIV 5
`endif

/* File: verilog/panel_sync_pkg.sv */
// Purpose: Types for the panel sync block
// Assumes: Constants live in the regs header
// Notes: None
package panel_sync_pkg;
  typedef enum logic [2:0] {st_idle, st_shift, st_s2l, st_line, st_l2f} seq_e;
  typedef struct packed {
    logic enable;
    logic frame_pol;
    logic line_pol;
    logic shift_pol;
    logic [3:0] bus_width;
    logic [7:0] pixel_clock_divisor;
  } ctrl_s;
  typedef struct packed {
    logic [7:0] l2f_wait;
    logic [7:0] line_width;
    logic [7:0] s2l_wait;
  } timing_s;
  typedef struct packed {
    logic [15:0] lines;
    logic [15:0] pixels;
  } geom_s;
  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic shift_clk;
  } pins_s;
endpackage

/* File: test/panel_sync_sva.sv */
// Purpose: Timing checker for the panel sync outputs
// Assumes: Bench sets divisor 2, width 1, waits 1 and 0, bus 2
// Notes: Checks apply only while the shift clock is moving
`timescale 1ns/10ps
`default_nettype none
module panel_sync_sva #(
  parameter int P1 = 3,
  parameter int TS = 6
) (
  // Clock and reset
  input wire logic display_source_clock,
  input wire logic arst_n,
  // Panel
  input wire logic frame_sync,
  input wire logic line_sync,
  input wire logic shift_clk
);
  logic [7:0] idle_r;
  logic [7:0] gap_r;
  wire run = idle_r < 8'h40;
  default clocking cb @(posedge display_source_clock); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge display_source_clock or negedge arst_n) begin
    if (!arst_n) begin
      idle_r <= 8'hff;
      gap_r <= 8'h00;
    end else begin
      idle_r <= $changed(shift_clk) ? 8'h00 : idle_r + {7'h0, idle_r != 8'hff};
      gap_r <= $rose(shift_clk) ? 8'h01 : gap_r + {7'h0, gap_r != 8'hff};
    end
  end
  sequence s_line_pulse;
    line_sync [*6] ##1 !line_sync;
  endsequence
  a_frame_lag: assert property ($rose(frame_sync) && run |->
    !$past(line_sync, 9) && $past(line_sync, 10)) else $error("frame lag wrong");
  a_line_width: assert property ($rose(line_sync) && run |-> s_line_pulse)
    else $error("line width wrong");
  a_shift_line: assert property ($rose(line_sync) && run |-> idle_r == 8'h02)
    else $error("line after shift too soon");
  a_frame_shift: assert property ($fell(frame_sync) && run |-> ##[0:6] $changed(shift_clk))
    else $error("shift late after frame");
  a_shift_gap: assert property ($rose(shift_clk) && run |-> gap_r >= TS)
    else $error("shift period short");
  a_pix_tick: assert property ($rose(shift_clk) && run |-> gap_r % P1 == 0)
    else $error("shift off pixel tick");
endmodule
bind passive_panel_sync_timing panel_sync_sva i_sva (
  .display_source_clock(display_source_clock),
  .arst_n(arst_n),
  .frame_sync(frame_sync),
  .line_sync(line_sync),
  .shift_clk(shift_clk)
);
`default_nettype wire

/* File: test/panel_sink.sv */
// Purpose: Passive panel model counting shifts and frames
// Assumes: Active high syncs and shift clock
// Notes: Counts are read by the bench
`timescale 1ns/10ps
`default_nettype none
module panel_sink (
  // Panel
  input wire logic shift_clk,
  input wire logic line_sync,
  input wire logic frame_sync,
  // Counts
  output int px_last,
  output int frames
);
  int px = 0;
  initial px_last = 0;
  initial frames = 0;
  always @(posedge shift_clk) px++;
  always @(posedge line_sync) begin
    px_last = px;
    px = 0;
  end
  always @(posedge frame_sync) frames++;
endmodule
`default_nettype wire

/* File: test/passive_panel_sync_timing_tb.sv */
// Purpose: Bench for the panel sync block
// Assumes: Avalon slave acks one cycle after a request
// Notes: Source clock 12 ns, divisor 2, bus width 2
`timescale 1ns/10ps
`default_nettype none
module passive_panel_sync_timing_tb;
  logic mclk = 0, src = 0, arst_n = 0, rd = 0, wr = 0;
  logic [3:0] adr = 4'h0, be = 4'hf;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [7:0] pix = 8'h5a, pdl;
  logic wait_q, fs, ls, sc;
  int px_last, frames, miscompares = 0, tests_run = 0;
  passive_panel_sync_timing i_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wait_q), .display_source_clock(src),
    .pixel_in(pix), .frame_sync(fs), .line_sync(ls), .shift_clk(sc), .panel_data_lines(pdl));
  panel_sink i_sink (.shift_clk(sc), .line_sync(ls), .frame_sync(fs), .px_last(px_last),
    .frames(frames));
  initial forever #5 mclk = ~mclk;
  initial begin
    #3;
    forever #6 src = ~src;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    while (wait_q !== 1'b0) begin
      @(posedge mclk);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_regs();
    bus(0, 4'h8, 0);
    chk(32'h0004_0010, q, "geom reset");
    bus(0, 4'h2, 0);
    chk(32'h0, q, "unmapped");
    bus(1, 4'h4, 32'h0001_0100);
    bus(0, 4'h4, 0);
    chk(32'h0001_0100, q, "timing");
  endtask
  task automatic t_run();
    int n = 0;
    bus(1, 4'h8, 32'h0002_0004);
    bus(1, 4'h0, 32'h0000_0221);
    while (frames < 3 && n < 20000) begin
      n++;
      @(posedge mclk);
    end
    chk(32'h1, {31'h0, frames >= 3}, "frames seen");
    chk(32'd4, px_last, "shifts per line");
    chk(32'h5a, {24'h0, pdl}, "data lines");
    bus(0, 4'hc, 0);
    chk(32'h4, q & 32'h4, "running");
  endtask
  task automatic t_pol();
    bus(1, 4'h0, 32'h0000_0220);
    repeat (200) @(posedge mclk);
    bus(1, 4'h0, 32'h0000_0226);
    repeat (100) @(posedge mclk);
    chk(32'h6, {29'h0, fs, ls, sc}, "pol frame line");
    bus(1, 4'h0, 32'h0000_0228);
    repeat (100) @(posedge mclk);
    chk(32'h1, {29'h0, fs, ls, sc}, "pol shift");
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_run();
    t_pol();
    close_out();
  end
endmodule
`default_nettype wire
